// [design/fdc_aux_defines.vh]
// Purpose: shared constants for the auxiliary command decoder
// Assumes: 50 MHz clock
// Notes:   opcodes are matched on the bits they fix
`ifndef FDC_AUX_DEFINES_VH
`define FDC_AUX_DEFINES_VH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OP_DUMP        8'h0e
`define OP_PERP        8'h12
`define OP_LOCK_LOW    7'h14
`define OP_READ_ID_LOW 6'h0a
`define OP_RELSEEK_LOW 6'h0f
`define OP_READ        5'h06
`define OP_READ_DEL    5'h0c
`define OP_WRITE       5'h05
`define OP_WRITE_DEL   5'h09
`define OP_READ_TRACK  5'h02
`define OP_VERIFY      5'h16

// ---------------------------------------------------------------
// command lengths, result counts, result values
// ---------------------------------------------------------------
`define LEN_ONE        4'h1
`define LEN_TWO        4'h2
`define LEN_THREE      4'h3
`define LEN_XFER       4'h9
`define RES_ONE        4'h1
`define RES_SEVEN      4'h7
`define RES_DUMP       4'ha
`define RES_INVALID    8'h80
`define ST0_SEEK_FAIL  8'h70
`define LOCK_RES_BIT   4

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_MHZ        50
`define STEP_TIME_US   3000

`endif

// [design/floppy_aux_command_decoder.v]
// Purpose: command decode and result sequencing for auxiliary commands
// Assumes: host strobes are one-cycle pulses on clk
// Notes:   the transfer engine does the disk work; this block seeks
//
// Function
// - dump byte seven is sectors per cylinder after format, else final sector.
// - perpendicular drive bits stay internal and never touch drive selects.
// - all read, write and verify commands share parameters and results.
// - with implied seek enabled a seek runs before the data transfer when the cylinder differs.
// - the implied seek adds no bytes and no interrupt sense step.
// - the addressed drive shows busy during the seek part.
// - an implied seek failure is reported in the normal result bytes.
// - on seek failure first status holds the error, cylinder the fail point.
// - read id has density in bit 6 and captures the first good id field.
// - read id returns three status bytes then cylinder, head, sector, size.
// - an unknown opcode is a no-op returning one byte 80h.
// - perpendicular byte: overwrite, drive bits 5..2, gap, write gate.
`timescale 1ns/10ps
`include "fdc_aux_defines.vh"

module floppy_aux_command_decoder #(
  parameter STEP_CYCLES = `STEP_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // host byte port
  input  wire       cmd_wr,
  input  wire [7:0] cmd_data,
  input  wire       res_rd,
  output reg  [7:0] res_data_r,
  output reg        res_valid_r,
  output reg        cmd_busy_r,
  output reg  [3:0] drive_busy_r,
  // configuration held elsewhere
  input  wire       implied_seek_enable,
  input  wire       fifo_disable,
  input  wire       poll_disable,
  input  wire [3:0] fifo_threshold,
  input  wire [7:0] precomp_start_track,
  input  wire [3:0] step_rate_time,
  input  wire [3:0] head_unload_time,
  input  wire [6:0] head_load_time,
  input  wire       non_dma_flag,
  input  wire       last_was_format,
  input  wire [7:0] sectors_per_cylinder,
  input  wire [7:0] final_sector_number,
  // transfer engine
  output reg        eng_start_r,
  output reg        eng_read_id_r,
  output reg  [7:0] eng_cmd_r,
  output reg  [1:0] eng_drive_r,
  output reg        eng_head_r,
  output reg  [7:0] eng_cyl_r,
  output reg  [7:0] eng_sec_r,
  output reg  [7:0] eng_size_r,
  output reg  [7:0] eng_eot_r,
  input  wire       eng_done,
  input  wire [7:0] eng_st0,
  input  wire [7:0] eng_st1,
  input  wire [7:0] eng_st2,
  input  wire [7:0] eng_c,
  input  wire [7:0] eng_h,
  input  wire [7:0] eng_r,
  input  wire [7:0] eng_n,
  // perpendicular and lock settings, internal use only
  output reg  [7:0] perp_mode_r,
  output reg        lock_r,
  // drive pins
  input  wire       seek_fault,
  output wire       step_pulse,
  output wire       step_dir
);

  localparam S_IDLE  = 3'd0;
  localparam S_PARAM = 3'd1;
  localparam S_EXEC  = 3'd2;
  localparam S_SEEK  = 3'd3;
  localparam S_ENG   = 3'd4;
  localparam S_RES   = 3'd5;

  reg  [2:0] state_r;
  reg  [7:0] prm [0:8];
  reg  [7:0] res_mem [0:9];
  reg  [7:0] present_cylinder [0:3];
  reg  [3:0] len_r;
  reg  [3:0] cnt_r;
  reg  [3:0] res_cnt_r;
  reg  [3:0] res_idx_r;
  reg        rel_r;
  reg        sk_start_r;
  reg  [7:0] sk_from_r;
  reg  [7:0] sk_to_r;
  wire       sk_done;
  wire       sk_fail;
  wire [7:0] sk_cyl;
  wire [1:0] drv;
  wire [8:0] rel_up;
  wire [8:0] rel_dn;
  integer    i;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function is_xfer;
    input [7:0] op;
    begin
      // only the low five bits tell the transfer commands apart
      is_xfer = (op[4:0] == `OP_READ) || (op[4:0] == `OP_READ_DEL) ||
                (op[4:0] == `OP_WRITE) || (op[4:0] == `OP_WRITE_DEL) ||
                (op[4:0] == `OP_READ_TRACK) || (op[4:0] == `OP_VERIFY);
    end
  endfunction

  function [3:0] cmd_len;
    input [7:0] op;
    begin
      if (op == `OP_DUMP)
        cmd_len = `LEN_ONE;
      else if (op[6:0] == `OP_LOCK_LOW)
        cmd_len = `LEN_ONE;
      else if (op == `OP_PERP)
        cmd_len = `LEN_TWO;
      else if (op[7] == 1'b0 && op[5:0] == `OP_READ_ID_LOW)
        cmd_len = `LEN_TWO;
      else if (op[7] == 1'b1 && op[5:0] == `OP_RELSEEK_LOW)
        cmd_len = `LEN_THREE;
      else if (is_xfer(op))
        cmd_len = `LEN_XFER;
      else
        cmd_len = 4'h0;
    end
  endfunction

  assign drv    = prm[1][1:0];
  assign rel_up = {1'b0, present_cylinder[drv]} + {1'b0, prm[2]};
  assign rel_dn = {1'b0, present_cylinder[drv]} - {1'b0, prm[2]};

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r      <= S_IDLE;
      len_r        <= 4'h0;
      cnt_r        <= 4'h0;
      res_cnt_r    <= 4'h0;
      res_idx_r    <= 4'h0;
      res_data_r   <= 8'h00;
      res_valid_r  <= 1'b0;
      cmd_busy_r   <= 1'b0;
      drive_busy_r <= 4'h0;
      rel_r        <= 1'b0;
      sk_start_r   <= 1'b0;
      sk_from_r    <= 8'h00;
      sk_to_r      <= 8'h00;
      eng_start_r  <= 1'b0;
      eng_read_id_r <= 1'b0;
      eng_cmd_r    <= 8'h00;
      eng_drive_r  <= 2'b00;
      eng_head_r   <= 1'b0;
      eng_cyl_r    <= 8'h00;
      eng_sec_r    <= 8'h00;
      eng_size_r   <= 8'h00;
      eng_eot_r    <= 8'h00;
      perp_mode_r  <= 8'h00;
      lock_r       <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        present_cylinder[i] <= 8'h00;
    end else begin
      sk_start_r  <= 1'b0;
      eng_start_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          res_valid_r <= 1'b0;
          if (cmd_wr) begin
            prm[0]     <= cmd_data;
            len_r      <= cmd_len(cmd_data);
            cnt_r      <= 4'h1;
            cmd_busy_r <= 1'b1;
            if (cmd_len(cmd_data) == 4'h0) begin
              res_mem[0] <= `RES_INVALID;
              res_cnt_r  <= `RES_ONE;
              res_idx_r  <= 4'h0;
              res_data_r <= `RES_INVALID;
              res_valid_r <= 1'b1;
              state_r    <= S_RES;
            end else if (cmd_len(cmd_data) == `LEN_ONE) begin
              state_r <= S_EXEC;
            end else begin
              state_r <= S_PARAM;
            end
          end
        end
        S_PARAM: begin
          if (cmd_wr) begin
            prm[cnt_r] <= cmd_data;
            cnt_r      <= cnt_r + 4'h1;
            if (cnt_r + 4'h1 == len_r)
              state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          eng_cmd_r   <= prm[0];
          eng_drive_r <= drv;
          eng_head_r  <= prm[1][2];
          eng_cyl_r   <= prm[2];
          eng_sec_r   <= prm[4];
          eng_size_r  <= prm[5];
          eng_eot_r   <= prm[6];
          rel_r       <= 1'b0;
          if (prm[0] == `OP_DUMP) begin
            res_mem[0] <= present_cylinder[0];
            res_mem[1] <= present_cylinder[1];
            res_mem[2] <= present_cylinder[2];
            res_mem[3] <= present_cylinder[3];
            res_mem[4] <= {step_rate_time, head_unload_time};
            res_mem[5] <= {head_load_time, non_dma_flag};
            res_mem[6] <= last_was_format ? sectors_per_cylinder :
                                            final_sector_number;
            res_mem[7] <= {lock_r, 1'b0, perp_mode_r[5:0]};
            res_mem[8] <= {1'b0, implied_seek_enable, fifo_disable,
                           poll_disable, fifo_threshold};
            res_mem[9] <= precomp_start_track;
            res_data_r <= present_cylinder[0];
            res_cnt_r  <= `RES_DUMP;
            res_idx_r  <= 4'h0;
            res_valid_r <= 1'b1;
            state_r    <= S_RES;
          end else if (prm[0][6:0] == `OP_LOCK_LOW) begin
            lock_r     <= prm[0][7];
            res_mem[0] <= {3'b000, prm[0][7], 4'h0};
            res_data_r <= {3'b000, prm[0][7], 4'h0};
            res_cnt_r  <= `RES_ONE;
            res_idx_r  <= 4'h0;
            res_valid_r <= 1'b1;
            state_r    <= S_RES;
          end else if (prm[0] == `OP_PERP) begin
            // drive bits change only under overwrite; no pin sees them
            perp_mode_r[1:0] <= prm[1][1:0];
            if (prm[1][7])
              perp_mode_r[5:2] <= prm[1][5:2];
            eng_drive_r <= eng_drive_r;
            cmd_busy_r <= 1'b0;
            state_r    <= S_IDLE;
          end else if (len_r == `LEN_THREE) begin
            rel_r      <= 1'b1;
            sk_from_r  <= present_cylinder[drv];
            sk_to_r    <= prm[0][6] ?
                          (rel_up[8] ? 8'hff : rel_up[7:0]) :
                          (rel_dn[8] ? 8'h00 : rel_dn[7:0]);
            sk_start_r <= 1'b1;
            drive_busy_r[drv] <= 1'b1;
            state_r    <= S_SEEK;
          end else if (len_r == `LEN_TWO) begin
            eng_read_id_r <= 1'b1;
            eng_start_r   <= 1'b1;
            state_r       <= S_ENG;
          end else if (implied_seek_enable && prm[2] != present_cylinder[drv]) begin
            sk_from_r  <= present_cylinder[drv];
            sk_to_r    <= prm[2];
            sk_start_r <= 1'b1;
            drive_busy_r[drv] <= 1'b1;
            state_r    <= S_SEEK;
          end else begin
            eng_read_id_r <= 1'b0;
            eng_start_r   <= 1'b1;
            state_r       <= S_ENG;
          end
        end
        S_SEEK: begin
          if (sk_done && !sk_start_r) begin
            present_cylinder[drv] <= sk_cyl;
            drive_busy_r[drv] <= 1'b0;
            if (rel_r) begin
              cmd_busy_r <= 1'b0;
              state_r    <= S_IDLE;
            end else if (sk_fail) begin
              // failure goes out as the transfer's own result bytes
              res_mem[0] <= `ST0_SEEK_FAIL | {5'h00, prm[1][2:0]};
              res_mem[1] <= 8'h00;
              res_mem[2] <= 8'h00;
              res_mem[3] <= sk_cyl;
              res_mem[4] <= prm[3];
              res_mem[5] <= prm[4];
              res_mem[6] <= prm[5];
              res_data_r <= `ST0_SEEK_FAIL | {5'h00, prm[1][2:0]};
              res_cnt_r  <= `RES_SEVEN;
              res_idx_r  <= 4'h0;
              res_valid_r <= 1'b1;
              state_r    <= S_RES;
            end else begin
              eng_read_id_r <= 1'b0;
              eng_start_r   <= 1'b1;
              state_r       <= S_ENG;
            end
          end
        end
        S_ENG: begin
          if (eng_done) begin
            res_mem[0] <= eng_st0;
            res_mem[1] <= eng_st1;
            res_mem[2] <= eng_st2;
            res_mem[3] <= eng_c;
            res_mem[4] <= eng_h;
            res_mem[5] <= eng_r;
            res_mem[6] <= eng_n;
            res_data_r <= eng_st0;
            res_cnt_r  <= `RES_SEVEN;
            res_idx_r  <= 4'h0;
            res_valid_r <= 1'b1;
            state_r    <= S_RES;
          end
        end
        S_RES: begin
          if (res_rd) begin
            if (res_idx_r + 4'h1 == res_cnt_r) begin
              res_valid_r <= 1'b0;
              cmd_busy_r  <= 1'b0;
              state_r     <= S_IDLE;
            end else begin
              res_idx_r  <= res_idx_r + 4'h1;
              res_data_r <= res_mem[res_idx_r + 4'h1];
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // head positioning
  // ---------------------------------------------------------------
  seek_stepper #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_seek (
    .clk         (clk),
    .rst         (rst),
    .start       (sk_start_r),
    .start_cyl   (sk_from_r),
    .target_cyl  (sk_to_r),
    .seek_fault  (seek_fault),
    .step_r      (step_pulse),
    .dir_r       (step_dir),
    .done_r      (sk_done),
    .fail_r      (sk_fail),
    .cyl_r       (sk_cyl)
  );

endmodule

// [design/seek_stepper.v]
// Purpose: steps a drive head from a start cylinder to a target
// Assumes: fault pin is asynchronous to clk
// Notes:   a fault ends the seek with the cylinder reached so far
`timescale 1ns/10ps
`include "fdc_aux_defines.vh"

module seek_stepper #(
  parameter STEP_CYCLES = `STEP_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // control
  input  wire       start,
  input  wire [7:0] start_cyl,
  input  wire [7:0] target_cyl,
  // drive pins
  input  wire       seek_fault,
  output reg        step_r,
  output reg        dir_r,
  // status
  output reg        done_r,
  output reg        fail_r,
  output reg  [7:0] cyl_r
);

  reg        flt_s1_r;
  reg        flt_s2_r;
  reg        run_r;
  reg [31:0] tmr_r;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flt_s1_r <= 1'b0;
      flt_s2_r <= 1'b0;
    end else begin
      flt_s1_r <= seek_fault;
      flt_s2_r <= flt_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // stepping
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r  <= 1'b0;
      tmr_r  <= 32'h0;
      step_r <= 1'b0;
      dir_r  <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      cyl_r  <= 8'h00;
    end else begin
      step_r <= 1'b0;
      done_r <= 1'b0;
      if (start) begin
        run_r  <= 1'b1;
        cyl_r  <= start_cyl;
        fail_r <= 1'b0;
        dir_r  <= (target_cyl > start_cyl);
        tmr_r  <= 32'h0;
      end else if (run_r) begin
        if (flt_s2_r) begin
          run_r  <= 1'b0;
          fail_r <= 1'b1;
          done_r <= 1'b1;
        end else if (cyl_r == target_cyl) begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end else if (tmr_r == STEP_CYCLES - 1) begin
          // one step per step period keeps the head settled
          tmr_r  <= 32'h0;
          step_r <= 1'b1;
          cyl_r  <= dir_r ? cyl_r + 8'h01 : cyl_r - 8'h01;
        end else begin
          tmr_r  <= tmr_r + 32'h1;
        end
      end
    end
  end

endmodule

// [sim/aux_decoder_sva.sv]
// Purpose: port checks for the auxiliary command decoder
// Assumes: one clock, rst asynchronous active high
// Notes:   bind stands at the foot of this file
`timescale 1ns/10ps
module aux_decoder_sva (
  // clock and reset
  input wire       clk,
  input wire       rst,
  // host port
  input wire       cmd_wr,
  input wire [7:0] cmd_data,
  input wire       res_rd,
  input wire [7:0] res_data_r,
  input wire       res_valid_r,
  input wire       cmd_busy_r,
  input wire [3:0] drive_busy_r,
  // engine, settings, pins
  input wire       eng_start_r,
  input wire       eng_read_id_r,
  input wire [1:0] eng_drive_r,
  input wire [7:0] perp_mode_r,
  input wire       lock_r,
  input wire       step_pulse
);
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // busy low marks a first byte; a refused write never gets here
  wire       idle_wr  = cmd_wr && !cmd_busy_r;
  wire       req_bit  = cmd_data[7];
  wire [1:0] low_bits = cmd_data[1:0];

  inv_code_a: assert property (
    idle_wr && (cmd_data == 8'hff || cmd_data == 8'h00) |=>
    res_valid_r && res_data_r == 8'h80) else $error("bad invalid reply");
  lock_res_a: assert property (
    idle_wr && cmd_data[6:0] == 7'h14 |-> ##2 res_valid_r &&
    res_data_r == {3'h0, lock_r, 4'h0} && lock_r == $past(req_bit, 2))
    else $error("bad lock reply");
  perp_low_a: assert property (
    idle_wr && cmd_data == 8'h12 ##1 cmd_wr |-> ##2
    perp_mode_r[1:0] == $past(low_bits, 2) && perp_mode_r[7:6] == 2'b00)
    else $error("bad perpendicular setting");
  perp_pins_a: assert property (
    $changed(perp_mode_r) |-> $stable(eng_drive_r) && !step_pulse)
    else $error("perpendicular bits leaked");
  res_hold_a: assert property (
    res_valid_r && !res_rd |=> res_valid_r && $stable(res_data_r))
    else $error("result byte dropped");
  res_busy_a: assert property (res_valid_r |-> cmd_busy_r)
    else $error("result outside command");
  step_busy_a: assert property (
    step_pulse |-> $onehot(drive_busy_r)) else $error("step without busy");
  seek_first_a: assert property (
    eng_start_r |-> drive_busy_r == 4'h0 && cmd_busy_r)
    else $error("transfer started during seek");
  rid_start_a: assert property (
    idle_wr && cmd_data[5:0] == 6'h0a && !cmd_data[7] ##1 cmd_wr |->
    ##2 eng_start_r && eng_read_id_r) else $error("read id not started");
  rid_cv: cover property (eng_start_r && eng_read_id_r);
  lock_cv: cover property (res_valid_r && res_data_r == 8'h10);
  step_cv: cover property (step_pulse);
endmodule

bind floppy_aux_command_decoder aux_decoder_sva i_aux_decoder_sva (
  .clk, .rst, .cmd_wr, .cmd_data, .res_rd, .res_data_r, .res_valid_r,
  .cmd_busy_r, .drive_busy_r, .eng_start_r, .eng_read_id_r, .eng_drive_r,
  .perp_mode_r, .lock_r, .step_pulse);

// [sim/engine_model.sv]
// Purpose: behavioural transfer engine answering start pulses
// Assumes: request fields hold from start until done
// Notes:   answer delay alternates fast and slow
`timescale 1ns/10ps
module engine_model #(
  parameter ID_CYL = 8'h27
) (
  // clock
  input  wire       clk,
  // request
  input  wire       eng_start_r,
  input  wire       eng_read_id_r,
  input  wire [1:0] eng_drive_r,
  input  wire       eng_head_r,
  input  wire [7:0] eng_cyl_r,
  input  wire [7:0] eng_sec_r,
  input  wire [7:0] eng_size_r,
  // answer
  output reg        eng_done,
  output reg  [7:0] eng_st0,
  output reg  [7:0] eng_st1,
  output reg  [7:0] eng_st2,
  output reg  [7:0] eng_c,
  output reg  [7:0] eng_h,
  output reg  [7:0] eng_r,
  output reg  [7:0] eng_n
);
  // ------------------------------------------------------------
  // answer timing
  // ------------------------------------------------------------
  reg [3:0] wait_r;
  reg       slow_r;
  reg       busy_r;
  initial begin
    {eng_done, busy_r, slow_r, wait_r} = 7'h00;
    {eng_st0, eng_st1, eng_st2, eng_c, eng_h, eng_r, eng_n} = 56'h0;
  end
  always @(posedge clk) begin
    eng_done <= 1'b0;
    // results are only good with done; they are inverted on every cycle without done
    {eng_st0, eng_st1, eng_st2, eng_c, eng_h, eng_r, eng_n} <=
      ~{eng_st0, eng_st1, eng_st2, eng_c, eng_h, eng_r, eng_n};
    if (eng_start_r) begin
      busy_r <= 1'b1;
      wait_r <= slow_r ? 4'h9 : 4'h1;
      slow_r <= ~slow_r;
    end else if (busy_r && wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (busy_r) begin
      busy_r   <= 1'b0;
      eng_done <= 1'b1;
      eng_st0  <= {5'h0, eng_head_r, eng_drive_r};
      eng_st1  <= 8'h00;
      eng_st2  <= 8'h00;
      eng_c    <= eng_read_id_r ? ID_CYL : eng_cyl_r;
      eng_h    <= {7'h0, eng_head_r};
      eng_r    <= eng_read_id_r ? 8'h01 : eng_sec_r;
      eng_n    <= eng_read_id_r ? 8'h02 : eng_size_r;
    end
  end
endmodule

// [sim/testbench.sv]
// Purpose: self-checking bench for the auxiliary command decoder
// Assumes: inputs change on the falling edge
// Notes:   results are noted in a queue and checked by a monitor
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam       ID_C = 8'h27;
  reg              clk, rst, cmd_wr, res_rd, seek_fault, lock_e;
  reg              implied_seek_enable, fifo_disable, poll_disable;
  reg              non_dma_flag, last_was_format;
  reg  [7:0]       cmd_data, precomp_start_track, v, op, perp_e;
  reg  [7:0]       sectors_per_cylinder, final_sector_number;
  reg  [3:0]       fifo_threshold, step_rate_time, head_unload_time;
  reg  [3:0]       busy_seen;
  reg  [6:0]       head_load_time;
  reg  [15:0]      seed;
  reg  [7:0]       q[$];
  reg  [7:0]       present_cylinder[0:3];
  integer          err_count, n_checks, i;
  wire [7:0]       res_data_r, eng_cmd_r, eng_cyl_r, eng_sec_r, eng_size_r;
  wire [7:0]       eng_eot_r, perp_mode_r, eng_st0, eng_st1, eng_st2;
  wire [7:0]       eng_c, eng_h, eng_r, eng_n;
  wire [3:0]       drive_busy_r;
  wire [1:0]       eng_drive_r;
  wire             res_valid_r, cmd_busy_r, eng_start_r, eng_read_id_r;
  wire             eng_head_r, eng_done, lock_r, step_pulse, step_dir;

  floppy_aux_command_decoder #(.STEP_CYCLES(4)) i_floppy_aux_command_decoder (
    .clk, .rst, .cmd_wr, .cmd_data, .res_rd, .res_data_r, .res_valid_r,
    .cmd_busy_r, .drive_busy_r, .implied_seek_enable, .fifo_disable,
    .poll_disable, .fifo_threshold, .precomp_start_track, .step_rate_time,
    .head_unload_time, .head_load_time, .non_dma_flag, .last_was_format,
    .sectors_per_cylinder, .final_sector_number, .eng_start_r,
    .eng_read_id_r, .eng_cmd_r, .eng_drive_r, .eng_head_r, .eng_cyl_r,
    .eng_sec_r, .eng_size_r, .eng_eot_r, .eng_done, .eng_st0, .eng_st1,
    .eng_st2, .eng_c, .eng_h, .eng_r, .eng_n, .perp_mode_r, .lock_r,
    .seek_fault, .step_pulse, .step_dir);
  engine_model #(.ID_CYL(ID_C)) i_engine_model (
    .clk, .eng_start_r, .eng_read_id_r, .eng_drive_r, .eng_head_r,
    .eng_cyl_r, .eng_sec_r, .eng_size_r, .eng_done, .eng_st0, .eng_st1,
    .eng_st2, .eng_c, .eng_h, .eng_r, .eng_n);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function [7:0] get_rnd();
    begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      get_rnd = seed[7:0];
    end
  endfunction
  task chk_out(input [7:0] got, input [7:0] want);
    begin
      n_checks = n_checks + 1;
      if (got !== want) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task chk_res;
    begin
      if (q.size() == 0) chk_out(res_data_r, 8'hxx);
      else chk_out(res_data_r, q.pop_front());
    end
  endtask
  task put(input [7:0] b);
    begin
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_data = b;
    end
  endtask
  task put_end;
    begin
      @(negedge clk);
      cmd_wr = 1'b0;
    end
  endtask
  task wait_idle(input [63:0] name);
    integer k;
    begin
      k = 0;
      repeat (3) @(negedge clk);
      while ((cmd_busy_r !== 1'b0 || q.size() != 0) && k < 3000) begin
        @(negedge clk);
        k = k + 1;
      end
      if (k == 3000) err_count = err_count + 1;
      $display("test %0s done", name);
    end
  endtask
  task wait_start(input rid, input [7:0] cmd);
    integer k;
    begin
      k = 0;
      while (eng_start_r !== 1'b1 && k < 500) begin
        @(negedge clk);
        k = k + 1;
      end
      chk_out({7'h0, eng_read_id_r}, {7'h0, rid});
      chk_out(eng_cmd_r, cmd);
    end
  endtask
  // nine bytes, same layout for every transfer opcode
  task xfer(input [7:0] o, input [2:0] hd, input [7:0] c, input [7:0] r);
    begin
      put(o);
      put({5'h0, hd});
      put(c);
      put({7'h0, hd[2]});
      put(r);
      put(8'h02);
      put(8'h12);
      put(8'h1b);
      put(8'hff);
      put_end;
    end
  endtask
  task dump_exp;
    begin
      put(8'h0e);
      for (i = 0; i < 4; i = i + 1) q.push_back(present_cylinder[i]);
      q.push_back({step_rate_time, head_unload_time});
      q.push_back({head_load_time, non_dma_flag});
      q.push_back(last_was_format ? sectors_per_cylinder :
                  final_sector_number);
      q.push_back({lock_e, 1'b0, perp_e[5:0]});
      q.push_back({1'b0, implied_seek_enable, fifo_disable, poll_disable,
                   fifo_threshold});
      q.push_back(precomp_start_track);
      put_end;
      wait_idle("dump");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  // ------------------------------------------------------------
  // monitor, watchdog, sequence
  // ------------------------------------------------------------
  always @(negedge clk) begin
    busy_seen = busy_seen | drive_busy_r;
    if (res_rd) res_rd = 1'b0;
    else if (res_valid_r === 1'b1) begin
      chk_res;
      res_rd = 1'b1;
    end
  end
  initial begin
    #600000;
    err_count = err_count + 1;
    final_report;
  end
  initial begin
    {rst, cmd_wr, res_rd, seek_fault, implied_seek_enable} = 5'h10;
    {cmd_data, busy_seen, perp_e, lock_e} = 21'h0;
    {err_count, n_checks, seed} = {32'h0, 32'h0, 16'h5c74};
    for (i = 0; i < 4; i = i + 1) present_cylinder[i] = 8'h00;
    v = get_rnd();
    {fifo_disable, poll_disable, non_dma_flag, fifo_threshold} = v[6:0];
    {last_was_format, head_load_time} = v;
    v = get_rnd();
    {step_rate_time, head_unload_time} = v;
    precomp_start_track = get_rnd();
    sectors_per_cylinder = get_rnd();
    final_sector_number = get_rnd();
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      put(i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'h7b);
      q.push_back(8'h80);
      put_end;
      wait_idle("invalid");
    end
    for (i = 0; i < 2; i = i + 1) begin
      lock_e = ~i[0];
      put({lock_e, 7'h14});
      q.push_back({3'h0, lock_e, 4'h0});
      put_end;
      wait_idle("lock");
      chk_out({7'h0, lock_r}, {7'h0, lock_e});
    end
    v = get_rnd();
    perp_e = {4'h0, 4'h1 << v[1:0]};
    perp_e = {2'b00, perp_e[3:0], v[3:2]};
    put(8'h12);
    put({2'b10, perp_e[5:0]});
    put_end;
    wait_idle("perp");
    put(8'h12);
    put({6'h0f, ~v[3:2]});
    put_end;
    wait_idle("perp");
    perp_e[1:0] = ~v[3:2];
    chk_out(perp_mode_r, perp_e);
    busy_seen = 4'h0;
    put(8'hcf);
    put(8'h01);
    put(8'h03);
    put_end;
    wait_idle("relseek");
    present_cylinder[1] = 8'h03;
    chk_out({7'h0, step_dir}, 8'h01);
    chk_out({4'h0, busy_seen}, 8'h02);
    put(8'h4a);
    put(8'h06);
    q = '{8'h06, 8'h0, 8'h0, ID_C, 8'h01, 8'h01, 8'h02};
    put_end;
    wait_start(1'b1, 8'h4a);
    wait_idle("read id");
    for (i = 0; i < 6; i = i + 1) begin
      op = {3'b010, i == 0 ? 5'h06 : i == 1 ? 5'h0c : i == 2 ? 5'h05 :
            i == 3 ? 5'h09 : i == 4 ? 5'h02 : 5'h16};
      v = get_rnd();
      q = '{{5'h0, v[2:0]}, 8'h0, 8'h0, v, {7'h0, v[2]}, ~v, 8'h02};
      xfer(op, v[2:0], v, ~v);
      wait_start(1'b0, op);
      chk_out(eng_eot_r, 8'h12);
      wait_idle("transfer");
    end
    implied_seek_enable = 1'b1;
    busy_seen = 4'h0;
    q = '{8'h02, 8'h0, 8'h0, 8'h02, 8'h0, 8'h01, 8'h02};
    xfer(op, 3'h2, 8'h02, 8'h01);
    wait_start(1'b0, op);
    chk_out(eng_cyl_r, 8'h02);
    wait_idle("implied");
    present_cylinder[2] = 8'h02;
    chk_out({4'h0, busy_seen}, 8'h04);
    seek_fault = 1'b1;
    q = '{8'h73, 8'h0, 8'h0, 8'h00, 8'h0, 8'h05, 8'h02};
    xfer(op, 3'h3, 8'h05, 8'h05);
    wait_idle("fault");
    seek_fault = 1'b0;
    dump_exp;
    last_was_format = ~last_was_format;
    dump_exp;
    final_report;
  end
endmodule
